// ===== rtl/lpc_top.sv
// Module: landing-pad control-flow check for one hart
//
// Overview of operation
// - Landing pad is the AUIPC opcode with destination register zero.
// - JALR target is rs1 value plus sign-extended 12-bit immediate.
// - JAL is a direct pc-relative transfer within one mebibyte.
// - Branches, compressed jump and jump-and-link are direct; never set state.
// - Compressed jump-and-link-register writes pc plus two to x1.
// - Compressed jump-register from x1/x5 is return, else indirect jump.
// - JAL or JALR with nonzero destination is a call.
// - Register-based calls are indirect; immediate-based calls are direct.
// - JALR to zero register from x1/x5 is a return.
// - JALR to zero register from other sources is an indirect jump.
// - With enforcement active, indirect calls and jumps set the expected state.
// - Expected state set and target not a landing pad raises a fault.
// - Landing pad carries a 20-bit label compared with the expected label.
// - Landing pad is a no-op when enforcement is off.
// - With enforcement off, no pad is required and no fault raised.
// - Each privilege mode has its own enable; current mode's applies.
// - Status-register access instructions must be present with this block.
// - Expected state resets to not required.
// - Fault reports cause 18 and trap value code 2.
// - Fault on misaligned target or mismatched nonzero label, else clear state.
// - Indirect transfers through x7 are software guarded and set nothing.
`timescale 1ns/10ps
`default_nettype none

module lpc_top #(
    parameter int XLEN = 32
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Per-mode enables
    input wire logic EN_U_I,
    input wire logic EN_S_I,
    input wire logic EN_M_I,
    input wire logic [1:0] PRIV_I,
    // Instruction at retire
    input wire logic RETIRE_I,
    input wire logic OTHER_TRAP_I,
    input wire logic [31:0] INSTR_I,
    input wire logic [XLEN-1:0] PC_I,
    input wire logic [XLEN-1:0] RS1_VAL_I,
    input wire logic [XLEN-1:0] X7_VAL_I,
    // Results
    output logic [XLEN-1:0] TARGET_O,
    output logic [XLEN-1:0] LINK_VAL_O,
    output logic [4:0] LINK_REG_O,
    output logic LINK_WE_O,
    output logic [2:0] XFER_O,
    output logic FAULT_O,
    output logic [5:0] CAUSE_O,
    output logic [XLEN-1:0] TVAL_O,
    output logic PAD_STATE_O
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    lpc_pkg::lpc_class_t cls;
    lpc_pkg::lpc_pad_state_t pad_q;
    lpc_pkg::lpc_pad_state_t pad_d;
    logic enf;
    logic fault;
    logic [XLEN-1:0] target;
    logic [XLEN-1:0] imm_i;
    logic [XLEN-1:0] imm_j;
    logic [XLEN-1:0] imm_b;
    logic [lpc_pkg::LABEL_W-1:0] pad_label_field;
    logic label_bad;

    lpc_classify u_cls (
        .instr_i(INSTR_I),
        .class_o(cls)
    );

    always_comb begin
        case (PRIV_I)
            lpc_pkg::PRIV_U: enf = EN_U_I;
            lpc_pkg::PRIV_S: enf = EN_S_I;
            lpc_pkg::PRIV_M: enf = EN_M_I;
            default: enf = 1'b0;
        endcase
    end

    assign imm_i = {{(XLEN-12){INSTR_I[31]}}, INSTR_I[31:20]};
    assign imm_j = {{(XLEN-20){INSTR_I[31]}}, INSTR_I[19:12], INSTR_I[20],
                    INSTR_I[30:21], 1'b0};
    assign imm_b = {{(XLEN-12){INSTR_I[31]}}, INSTR_I[7], INSTR_I[30:25],
                    INSTR_I[11:8], 1'b0};
    assign pad_label_field = INSTR_I[31:lpc_pkg::LABEL_LSB];

    always_comb begin
        target = PC_I;
        if (!cls.is_comp && INSTR_I[6:0] == lpc_pkg::OPC_JALR) begin
            target = RS1_VAL_I + imm_i;
        end else if (!cls.is_comp && INSTR_I[6:0] == lpc_pkg::OPC_JAL) begin
            target = PC_I + imm_j;
        end else if (!cls.is_comp && INSTR_I[6:0] == lpc_pkg::OPC_BRANCH) begin
            target = PC_I + imm_b;
        end else if (cls.is_comp && (cls.xfer == lpc_pkg::XFER_INDIRECT_CALL
                     || cls.xfer == lpc_pkg::XFER_RETURN
                     || cls.xfer == lpc_pkg::XFER_INDIRECT_JUMP)) begin
            target = RS1_VAL_I;
        end
    end

    // ------------------------------------------------------------
    // Landing-pad check
    // ------------------------------------------------------------
    assign label_bad = (pad_label_field != '0)
                       && (pad_label_field != X7_VAL_I[31:lpc_pkg::LABEL_LSB]);
    // status access is provided by the surrounding pipeline
    always_comb begin
        fault = 1'b0;
        if (enf && pad_q == lpc_pkg::pad_required && RETIRE_I) begin
            if (!cls.is_pad) begin
                fault = 1'b1;
            end else if (PC_I[1:0] != 2'h0) begin
                fault = 1'b1;
            end else if (label_bad) begin
                fault = 1'b1;
            end
        end
    end

    always_comb begin
        pad_d = pad_q;
        if (RETIRE_I && !OTHER_TRAP_I && !fault) begin
            if (!enf) begin
                pad_d = lpc_pkg::pad_not_required;
            end else if (cls.sets_pad) begin
                pad_d = lpc_pkg::pad_required;
            end else if (cls.is_pad) begin
                pad_d = lpc_pkg::pad_not_required;
            end
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            pad_q <= lpc_pkg::pad_not_required;
        end else begin
            pad_q <= pad_d;
        end
    end

    // ------------------------------------------------------------
    // Registered results
    // ------------------------------------------------------------
    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            FAULT_O <= 1'b0;
            CAUSE_O <= '0;
            TVAL_O <= '0;
        end else begin
            FAULT_O <= fault;
            CAUSE_O <= fault ? lpc_pkg::CAUSE_SW_CHECK : '0;
            TVAL_O <= fault ? XLEN'(lpc_pkg::TVAL_PAD_FAULT) : '0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SYS_RST_I) begin
            TARGET_O <= '0;
            LINK_VAL_O <= '0;
            LINK_REG_O <= '0;
            LINK_WE_O <= 1'b0;
            XFER_O <= '0;
        end else begin
            TARGET_O <= target;
            LINK_VAL_O <= PC_I + (cls.is_comp ? XLEN'(lpc_pkg::PC_STEP_C)
                                              : XLEN'(3'h4));
            LINK_REG_O <= cls.link_reg;
            LINK_WE_O <= RETIRE_I && !fault && !OTHER_TRAP_I && cls.links;
            XFER_O <= RETIRE_I ? 3'(cls.xfer) : '0;
        end
    end

    assign PAD_STATE_O = (pad_q == lpc_pkg::pad_required);

endmodule // lpc_top

`default_nettype wire

// ===== rtl/lpc_pkg.sv
// Package: constants and carrier types for the landing-pad check block
package lpc_pkg;

    // ------------------------------------------------------------
    // Instruction encoding
    // ------------------------------------------------------------
    localparam logic [6:0] OPC_AUIPC = 7'h17;
    localparam logic [6:0] OPC_JAL = 7'h6F;
    localparam logic [6:0] OPC_JALR = 7'h67;
    localparam logic [6:0] OPC_BRANCH = 7'h63;
    localparam logic [1:0] QUAD_C2 = 2'h2;
    localparam logic [1:0] QUAD_C1 = 2'h1;
    localparam logic [2:0] CF3_CJR = 3'h4;
    localparam logic [2:0] CF3_CJ = 3'h5;
    localparam logic [2:0] CF3_CJAL = 3'h1;
    localparam logic [4:0] REG_ZERO = 5'h00;
    localparam logic [4:0] REG_RA = 5'h01;
    localparam logic [4:0] REG_ALT_RA = 5'h05;
    localparam logic [4:0] REG_LABEL = 5'h07;
    localparam int LABEL_W = 20;
    localparam int LABEL_LSB = 12;

    // ------------------------------------------------------------
    // Fault reporting and compressed-instruction link step
    // ------------------------------------------------------------
    localparam logic [5:0] CAUSE_SW_CHECK = 6'h12;
    localparam logic [3:0] TVAL_PAD_FAULT = 4'h2;
    localparam logic [1:0] PC_STEP_C = 2'h2;

    // Expected-landing-pad state
    typedef enum logic {
        pad_not_required,
        pad_required
    } lpc_pad_state_t;

    // Privilege modes
    typedef enum logic [1:0] {
        PRIV_U = 2'h0,
        PRIV_S = 2'h1,
        PRIV_M = 2'h3
    } lpc_priv_t;

    // Transfer classes
    typedef enum logic [2:0] {
        XFER_NONE,
        XFER_DIRECT,
        XFER_DIRECT_CALL,
        XFER_INDIRECT_CALL,
        XFER_RETURN,
        XFER_INDIRECT_JUMP
    } lpc_xfer_t;

    // Result of classifying one instruction
    typedef struct packed {
        lpc_xfer_t xfer;
        logic is_pad;
        logic is_comp;
        logic sets_pad;
        logic links;
        logic [4:0] link_reg;
    } lpc_class_t;

endpackage : lpc_pkg

// ===== rtl/lpc_classify.sv
// Module: combinational classification of control-transfer instructions
`timescale 1ns/10ps
`default_nettype none

module lpc_classify (
    // Instruction
    input wire logic [31:0] instr_i,
    // Result
    output var lpc_pkg::lpc_class_t class_o
);

    logic [4:0] rd;
    logic [4:0] rs1;
    logic [4:0] c_rs1;
    logic [4:0] c_rs2;
    logic c_b12;
    logic is_link;

    function automatic logic link_reg_f(input logic [4:0] r);
        link_reg_f = (r == lpc_pkg::REG_RA) || (r == lpc_pkg::REG_ALT_RA);
    endfunction

    assign rd = instr_i[11:7];
    assign rs1 = instr_i[19:15];
    assign c_rs1 = instr_i[11:7];
    assign c_rs2 = instr_i[6:2];
    assign c_b12 = instr_i[12];
    assign is_link = link_reg_f(rs1);

    always_comb begin
        class_o = '0;
        class_o.xfer = lpc_pkg::XFER_NONE;
        if (instr_i[1:0] == 2'h3) begin
            case (instr_i[6:0])
                lpc_pkg::OPC_AUIPC: begin
                    class_o.is_pad = (rd == lpc_pkg::REG_ZERO);
                end
                lpc_pkg::OPC_JAL: begin
                    class_o.xfer = (rd != lpc_pkg::REG_ZERO) ? lpc_pkg::XFER_DIRECT_CALL
                                                             : lpc_pkg::XFER_DIRECT;
                    class_o.links = (rd != lpc_pkg::REG_ZERO);
                    class_o.link_reg = rd;
                end
                lpc_pkg::OPC_JALR: begin
                    class_o.links = (rd != lpc_pkg::REG_ZERO);
                    class_o.link_reg = rd;
                    if (rd != lpc_pkg::REG_ZERO) begin
                        class_o.xfer = lpc_pkg::XFER_INDIRECT_CALL;
                    end else if (is_link) begin
                        class_o.xfer = lpc_pkg::XFER_RETURN;
                    end else begin
                        class_o.xfer = lpc_pkg::XFER_INDIRECT_JUMP;
                    end
                    class_o.sets_pad = (rd != lpc_pkg::REG_ZERO || !is_link)
                                       && (rs1 != lpc_pkg::REG_LABEL);
                end
                lpc_pkg::OPC_BRANCH: begin
                    class_o.xfer = lpc_pkg::XFER_DIRECT;
                end
                default: begin
                    class_o.xfer = lpc_pkg::XFER_NONE;
                end
            endcase
        end else begin
            class_o.is_comp = 1'b1;
            if (instr_i[1:0] == lpc_pkg::QUAD_C2 && instr_i[15:13] == lpc_pkg::CF3_CJR
                && c_rs2 == lpc_pkg::REG_ZERO && c_rs1 != lpc_pkg::REG_ZERO) begin
                if (c_b12) begin
                    class_o.xfer = lpc_pkg::XFER_INDIRECT_CALL;
                    class_o.links = 1'b1;
                    class_o.link_reg = lpc_pkg::REG_RA;
                    class_o.sets_pad = (c_rs1 != lpc_pkg::REG_LABEL);
                end else if (link_reg_f(c_rs1)) begin
                    class_o.xfer = lpc_pkg::XFER_RETURN;
                end else begin
                    class_o.xfer = lpc_pkg::XFER_INDIRECT_JUMP;
                    class_o.sets_pad = (c_rs1 != lpc_pkg::REG_LABEL);
                end
            end else if (instr_i[1:0] == lpc_pkg::QUAD_C1
                         && instr_i[15:13] == lpc_pkg::CF3_CJ) begin
                class_o.xfer = lpc_pkg::XFER_DIRECT;
            end else if (instr_i[1:0] == lpc_pkg::QUAD_C1
                         && instr_i[15:13] == lpc_pkg::CF3_CJAL) begin
                class_o.xfer = lpc_pkg::XFER_DIRECT_CALL;
                class_o.links = 1'b1;
                class_o.link_reg = lpc_pkg::REG_RA;
            end else if (instr_i[1:0] == lpc_pkg::QUAD_C1 && instr_i[15:14] == 2'h3) begin
                class_o.xfer = lpc_pkg::XFER_DIRECT;
            end
        end
    end

endmodule // lpc_classify

`default_nettype wire

// ===== dv/lpc_assertions.sv
// Checker: port-level properties of the landing-pad check block
`timescale 1ns/10ps
`default_nettype none

module lpc_chk #(
    parameter int XLEN = 32
) (
    // Clock and reset
    input wire logic CLK_I,
    input wire logic SYS_RST_I,
    // Inputs
    input wire logic EN_U_I,
    input wire logic EN_S_I,
    input wire logic EN_M_I,
    input wire logic [1:0] PRIV_I,
    input wire logic RETIRE_I,
    input wire logic OTHER_TRAP_I,
    input wire logic [31:0] INSTR_I,
    input wire logic [XLEN-1:0] PC_I,
    // Outputs
    input wire logic [2:0] XFER_O,
    input wire logic FAULT_O,
    input wire logic [5:0] CAUSE_O,
    input wire logic [XLEN-1:0] TVAL_O,
    input wire logic PAD_STATE_O
);
    logic en;
    logic jr0;
    logic [4:0] rs;
    assign en = PRIV_I == 2'h0 ? EN_U_I : PRIV_I == 2'h1 ? EN_S_I : PRIV_I == 2'h3 && EN_M_I;
    assign rs = INSTR_I[19:15];
    // Enforced register jump to x0, retiring with no pad pending
    assign jr0 = RETIRE_I && en && !PAD_STATE_O && !OTHER_TRAP_I && INSTR_I[11:0] == 12'h067;
    // ----------
    // Properties
    // ----------
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (SYS_RST_I);
    property p_rst;
        $fell(SYS_RST_I) |-> !PAD_STATE_O && !FAULT_O;
    endproperty
    a_rst: assert property (p_rst) else $error("state set after reset");
    property p_hold;
        !RETIRE_I |=> $stable(PAD_STATE_O) && XFER_O == 3'h0 && !FAULT_O;
    endproperty
    a_hold: assert property (p_hold) else $error("change without retire");
    property p_cause;
        CAUSE_O == (FAULT_O ? lpc_pkg::CAUSE_SW_CHECK : 6'h00)
            && (!FAULT_O || TVAL_O == XLEN'(lpc_pkg::TVAL_PAD_FAULT));
    endproperty
    a_cause: assert property (p_cause) else $error("wrong fault cause");
    property p_off;
        RETIRE_I && !en && !OTHER_TRAP_I |=> !FAULT_O && !PAD_STATE_O;
    endproperty
    a_off: assert property (p_off) else $error("active while disabled");
    property p_ijmp;
        jr0 && !(rs inside {5'h01, 5'h05, 5'h07}) |=> PAD_STATE_O && XFER_O == 3'h5;
    endproperty
    a_ijmp: assert property (p_ijmp) else $error("jump left state clear");
    property p_guard;
        jr0 && rs == 5'h07 |=> !PAD_STATE_O && XFER_O == 3'h5;
    endproperty
    a_guard: assert property (p_guard) else $error("guarded jump set state");
    property p_pad;
        RETIRE_I && en && PAD_STATE_O && !OTHER_TRAP_I && INSTR_I[11:0] == 12'h017
            && PC_I[1:0] == 2'h0
            && INSTR_I[31:12] == 20'h0_0000 |=> !FAULT_O && !PAD_STATE_O;
    endproperty
    a_pad: assert property (p_pad) else $error("good pad refused");
    property p_bad;
        RETIRE_I && en && PAD_STATE_O && !OTHER_TRAP_I && INSTR_I[6:0] != 7'h17
            |=> FAULT_O && PAD_STATE_O;
    endproperty
    a_bad: assert property (p_bad) else $error("missing pad not caught");
    cover property (FAULT_O);
    cover property ($rose(PAD_STATE_O));
    cover property ($fell(PAD_STATE_O) && !FAULT_O);
endmodule // lpc_chk

bind lpc_top lpc_chk #(.XLEN(XLEN)) u_chk (
    .CLK_I(CLK_I), .SYS_RST_I(SYS_RST_I), .EN_U_I(EN_U_I), .EN_S_I(EN_S_I), .EN_M_I(EN_M_I),
    .PRIV_I(PRIV_I), .RETIRE_I(RETIRE_I), .OTHER_TRAP_I(OTHER_TRAP_I), .INSTR_I(INSTR_I),
    .PC_I(PC_I), .XFER_O(XFER_O), .FAULT_O(FAULT_O), .CAUSE_O(CAUSE_O), .TVAL_O(TVAL_O),
    .PAD_STATE_O(PAD_STATE_O)
);

`default_nettype wire

// ===== dv/lpc_top_tb.sv
// Testbench: directed and random retire traffic for the landing-pad check block
`timescale 1ns/10ps
`default_nettype none

module lpc_top_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] en = 3'h7;
    logic [1:0] priv = 2'h3;
    logic ret = 1'b0;
    logic trap = 1'b0;
    logic [31:0] ins = 32'h0000_0013;
    logic [31:0] pc = 32'h0000_0000;
    logic [31:0] rv = 32'h0000_0000;
    logic [31:0] x7 = 32'h0000_0000;
    logic [31:0] tgt, lval, tval, e_t, e_lv;
    logic [4:0] lreg, e_lr;
    logic [2:0] xf, e_x;
    logic [5:0] cause;
    logic lwe, flt, st, e_f, e_lw, ck_x, ck_t;
    logic e_st = 1'b0;
    logic pv = 1'b0;
    logic [31:0] r = 32'h0000_2951;
    logic [4:0] rt [8] = '{5'h00, 5'h01, 5'h05, 5'h06, 5'h07, 5'h07, 5'h01, 5'h00};
    int bad_count = 0;
    int compares = 0;
    always #5 clk = ~clk;
    lpc_top #(.XLEN(32)) uut (
        .CLK_I(clk), .SYS_RST_I(rst), .EN_U_I(en[0]), .EN_S_I(en[1]), .EN_M_I(en[2]),
        .PRIV_I(priv), .RETIRE_I(ret), .OTHER_TRAP_I(trap), .INSTR_I(ins), .PC_I(pc),
        .RS1_VAL_I(rv), .X7_VAL_I(x7), .TARGET_O(tgt), .LINK_VAL_O(lval),
        .LINK_REG_O(lreg), .LINK_WE_O(lwe), .XFER_O(xf), .FAULT_O(flt),
        .CAUSE_O(cause), .TVAL_O(tval), .PAD_STATE_O(st)
    );
    function automatic logic [31:0] nx(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // Drive one cycle, check the previous one, then model this one
    task automatic go(input logic r_i, input logic [31:0] i, input logic [31:0] p,
                      input logic t, input logic [4:0] m);
        logic [2:0] x;
        logic [4:0] rs, lr;
        logic c, on, tt;
        logic [31:0] v;
        on = m[1:0] == 2'h0 ? m[2] : m[1:0] == 2'h1 ? m[3] : m[1:0] == 2'h3 && m[4];
        tt = t && on && !e_st;
        v = {r[31:1], 1'b0};
        @(posedge clk);
        ret <= r_i;
        ins <= i;
        pc <= p;
        trap <= tt;
        rv <= v;
        x7 <= {r[19:0], 12'h000};
        en <= m[4:2];
        priv <= m[1:0];
        @(negedge clk);
        if (pv) begin
            cmp(32'(st), 32'(e_st));
            cmp(32'(flt), 32'(e_f));
            cmp(32'(cause), e_f ? 32'h0000_0012 : '0);
            cmp(tval, e_f ? 32'h0000_0002 : '0);
            cmp(32'(xf), 32'(e_x));
            cmp(32'(lwe), 32'(e_lw));
            if (e_lw) cmp(32'(lreg), 32'(e_lr));
            if (e_lw) cmp(lval, e_lv);
            if (ck_t) cmp(tgt, e_t);
        end
        c = i[1:0] != 2'h3;
        rs = c ? i[11:7] : i[19:15];
        lr = c ? 5'h01 : i[11:7];
        x = 3'h0;
        if (!c && i[6:0] == 7'h63) x = 3'h1;
        else if (!c && i[6:0] == 7'h6f) x = lr != 5'h00 ? 3'h2 : 3'h1;
        else if (!c && i[6:0] == 7'h67)
            x = lr != 5'h00 ? 3'h3 : rs == 5'h01 || rs == 5'h05 ? 3'h4 : 3'h5;
        else if (i[1:0] == 2'h1 && i[14:13] == 2'h1) x = i[15] ? 3'h1 : 3'h2;
        else if (i[1:0] == 2'h1 && i[15:14] == 2'h3) x = 3'h1;
        else if (i[1:0] == 2'h2 && i[15:13] == 3'h4 && rs != 5'h00 && i[6:2] == 5'h00)
            x = i[12] ? 3'h3 : rs == 5'h01 || rs == 5'h05 ? 3'h4 : 3'h5;
        e_f = 1'b0;
        if (r_i && !on) e_st = 1'b0;
        else if (r_i && e_st) begin
            e_f = i[11:0] != 12'h017 || p[1:0] != 2'h0
                || (i[31:12] != 20'h0_0000 && i[31:12] != r[19:0]);
            e_st = e_f;
        end else if (r_i && !tt && (x == 3'h3 || x == 3'h5) && rs != 5'h07)
            e_st = 1'b1;
        ck_x = !e_f && !tt;
        ck_t = ck_x && r_i && (c ? x > 3'h2 : x > 3'h1);
        e_x = r_i ? x : 3'h0;
        e_lw = r_i && !e_f && !tt && (x == 3'h2 || x == 3'h3);
        e_lr = lr;
        e_lv = p + (c ? 32'h0000_0002 : 32'h0000_0004);
        e_t = c ? v : i[3] ? p + {{11{i[31]}}, i[31], i[19:12], i[20], i[30:21], 1'b0}
            : v + {{20{i[31]}}, i[31:20]};
        pv = 1'b1;
    endtask
    initial begin
        logic [31:0] i;
        logic [4:0] rd, rs;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        for (int m = 0; m < 32; m++) begin
            go(1'b1, 32'h0003_0067, 32'h0000_0100, 1'b0, 5'(m));
            go(1'b1, 32'h0000_0013, 32'h0000_0200, 1'b0, 5'(m));
            go(1'b1, 32'h0000_0017, 32'h0000_0302, 1'b0, 5'h1f);
            go(1'b1, 32'h0000_0017, 32'h0000_0300, 1'b0, 5'h1f);
        end
        // Reset in mid-run must drop a pending landing-pad requirement
        go(1'b1, 32'h0003_0067, 32'h0000_0100, 1'b0, 5'h1f);
        @(posedge clk);
        ret <= 1'b0;
        rst <= 1'b1;
        @(negedge clk);
        cmp(32'(st), 32'h0000_0001);
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        cmp(32'(st), 32'h0000_0000);
        cmp(32'(flt), 32'h0000_0000);
        e_st = 1'b0;
        pv = 1'b0;
        for (int n = 0; n < 4000; n++) begin
            rd = rt[r[2:0]];
            rs = rt[r[5:3]];
            case (r[30:28])
                3'h0, 3'h1: i = {r[31:21], 1'b0, rs, 3'h0, rd, 7'h67};
                3'h2: i = {r[31:12], rd, 7'h6f};
                3'h3: i = {r[31:20], rs, 3'h0, r[11:7], 7'h63};
                3'h4: i = {r[31:16], 3'h4, r[6], rs, 5'h00, 2'h2};
                3'h5: i = {r[31:16], r[7], r[13], r[13] ? r[6] : 1'b1, r[12:2], 2'h1};
                3'h6: i = {r[9] ? r[19:0] : r[8] ? r[31:12] : 20'h0_0000, 12'h017};
                default: i = {r[31:12], rd, 7'h13};
            endcase
            go(r[22] | r[23], i, {r[31:2], r[11] & r[12], 1'b0}, r[24] & r[25],
               {|r[15:14], |r[17:16], |r[19:18], r[21:20]});
            r = nx(r);
        end
        go(1'b0, 32'h0000_0013, 32'h0000_0000, 1'b0, 5'h1f);
        conclude;
    end
endmodule // lpc_top_tb

`default_nettype wire
